// file: rtl/wdrs_defs.vh
`ifndef WDRS_DEFS_VH
`define WDRS_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (APB byte addresses)
// ----------------------------------------------------------------
`define WDRS_OFS_STATUS 8'h00
`define WDRS_OFS_PWRCTL 8'h04
`define WDRS_OFS_WDCTL 8'h08

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define WDRS_SR_TIMEOUT_BIT 4
`define WDRS_SR_POWERDOWN_BIT 3

// ----------------------------------------------------------------
// Power control register fields
// ----------------------------------------------------------------
`define WDRS_PW_STACK_OVER_BIT 7
`define WDRS_PW_STACK_UNDER_BIT 6
`define WDRS_PW_WDT_RESET_BIT 4
`define WDRS_PW_EXT_RESET_BIT 3
`define WDRS_PW_RESET_INSTR_BIT 2
`define WDRS_PW_POWER_ON_BIT 1
`define WDRS_PW_BROWN_OUT_BIT 0
`define WDRS_PW_RST_VAL 8'h1c
`define WDRS_PW_WMASK 8'hdf

// ----------------------------------------------------------------
// Watchdog control register fields
// ----------------------------------------------------------------
`define WDRS_WC_SWEN_BIT 0
`define WDRS_WC_PSEL_LSB 1
`define WDRS_WC_PSEL_MSB 5
`define WDRS_WC_PSEL_RST 5'h0b
`define WDRS_WC_PSEL_MAX 5'h12

// ----------------------------------------------------------------
// Watchdog mode configuration encodings
// ----------------------------------------------------------------
`define WDRS_MODE_ALWAYS 2'h3
`define WDRS_MODE_SLEEP_OFF 2'h2
`define WDRS_MODE_SOFTWARE 2'h1
`define WDRS_MODE_OFF 2'h0

// ----------------------------------------------------------------
// Timing and vectors
// ----------------------------------------------------------------
`define WDRS_LFOSC_KHZ 31
`define WDRS_BASE_MS 1
`define WDRS_BASE_TICKS (`WDRS_LFOSC_KHZ * `WDRS_BASE_MS)
`define WDRS_PC_W 15
`define WDRS_RESET_VEC 16'h0000
`define WDRS_IRQ_VEC 16'h0004

`endif

// file: rtl/wdrs_wdt_cnt.v
`timescale 1ns/10ps
`include "wdrs_defs.vh"

module wdrs_wdt_cnt #(
  parameter CNT_W = 24,
  parameter BASE_TICKS = `WDRS_BASE_TICKS
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire tick_in,
  input wire clear_in,
  input wire [4:0] period_sel_in,
  output reg timeout_out
);

  // ----------------------------------------------------------------
  // Period limit
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] cnt_q;
  wire [4:0] sel_clamp;
  wire [CNT_W-1:0] base_w;
  wire [CNT_W-1:0] limit_w;

  // Periods above the top step clamp to the longest one
  assign sel_clamp = (period_sel_in > `WDRS_WC_PSEL_MAX) ?
                     `WDRS_WC_PSEL_MAX : period_sel_in;
  assign base_w = BASE_TICKS[CNT_W-1:0];
  assign limit_w = base_w << sel_clamp;

  // ----------------------------------------------------------------
  // Tick counter
  // ----------------------------------------------------------------
  // Counts low-frequency ticks, pulses once per expired period
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt_q <= {CNT_W{1'b0}};
      timeout_out <= 1'b0;
    end
    else
    begin
      timeout_out <= 1'b0;
      if (clear_in)
        cnt_q <= {CNT_W{1'b0}};
      else if (tick_in)
      begin
        if (cnt_q == limit_w - {{(CNT_W-1){1'b0}}, 1'b1})
        begin
          cnt_q <= {CNT_W{1'b0}};
          timeout_out <= 1'b1;
        end
        else
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // wdrs_wdt_cnt

// file: rtl/wdrs_top.v
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "wdrs_defs.vh"

module wdrs_top #(
  parameter PC_W = `WDRS_PC_W,
  parameter BASE_TICKS = `WDRS_BASE_TICKS
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire [1:0] watchdog_mode_cfg_in,
  input wire stack_reset_enable_in,
  input wire low_freq_int_osc_in,
  input wire ext_reset_pin_n_in,
  input wire brown_out_reset_in,
  input wire osc_fail_in,
  input wire clear_watchdog_instr_in,
  input wire reset_instr_in,
  input wire sleep_enter_in,
  input wire irq_wake_in,
  input wire global_irq_enable_in,
  input wire instr_retired_in,
  input wire stack_over_in,
  input wire stack_under_in,
  input wire [PC_W-1:0] pc_in,
  output reg core_reset_out,
  output reg pc_load_out,
  output reg [PC_W-1:0] pc_value_out,
  output reg irq_push_out,
  output reg asleep_out,
  output reg timeout_flag_out,
  output reg powerdown_flag_out
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_RUN = 3'b001;
  localparam ST_SLEEP = 3'b010;
  localparam ST_VEC = 3'b100;

  // Watchdog enable decode per configured mode
  function wdt_active;
    input [1:0] mode;
    input swen;
    input slp;
    begin
      case (mode)
        `WDRS_MODE_ALWAYS: wdt_active = 1'b1;
        `WDRS_MODE_SLEEP_OFF: wdt_active = ~slp;
        `WDRS_MODE_SOFTWARE: wdt_active = swen;
        default: wdt_active = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [2:0] lf_sync_q;
  reg [2:0] ext_sync_q;
  reg [2:0] brown_sync_q;
  reg cfg_valid_q;
  reg [1:0] mode_q;
  reg stk_rst_en_q;
  reg [2:0] st_q;
  reg [7:0] pwr_q;
  reg [7:0] pwr_d;
  reg timeout_d;
  reg powerdown_d;
  reg sw_enable_q;
  reg [4:0] period_sel_q;
  reg [31:0] rdata_d;
  reg unmapped_d;
  wire lf_tick;
  wire ev_brown;
  wire ev_ext;
  wire ev_wdt_rst;
  wire ev_wdt_wake;
  wire ev_irq_wake;
  wire ev_rinstr;
  wire ev_over;
  wire ev_under;
  wire ev_sleep;
  wire true_rst;
  wire asleep;
  wire wdt_expired;
  wire wdt_clear;
  wire apb_acc;
  wire pready_d;
  wire wr_en;
  wire [15:0] pc_next16;
  wire [15:0] reset_vec;
  wire [15:0] irq_vec;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops per pin, third flop for edge detect
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lf_sync_q <= 3'h0;
      ext_sync_q <= 3'h7;
      brown_sync_q <= 3'h0;
    end
    else
    begin
      lf_sync_q <= {lf_sync_q[1:0], low_freq_int_osc_in};
      ext_sync_q <= {ext_sync_q[1:0], ext_reset_pin_n_in};
      brown_sync_q <= {brown_sync_q[1:0], brown_out_reset_in};
    end
  end

  assign lf_tick = lf_sync_q[1] & ~lf_sync_q[2];

  // Configuration word captured once after reset release
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cfg_valid_q <= 1'b0;
      mode_q <= `WDRS_MODE_OFF;
      stk_rst_en_q <= 1'b0;
    end
    else if (!cfg_valid_q)
    begin
      cfg_valid_q <= 1'b1;
      mode_q <= watchdog_mode_cfg_in;
      stk_rst_en_q <= stack_reset_enable_in;
    end
  end

  // ----------------------------------------------------------------
  // Event decode, highest priority first, except ev_wdt_wake, which ranks below ev_under
  // ----------------------------------------------------------------
  assign asleep = st_q[1];
  assign ev_brown = brown_sync_q[1] & ~brown_sync_q[2];
  assign ev_ext = ~ext_sync_q[1] & ext_sync_q[2];
  // timeout in sleep is a wake
  assign ev_wdt_rst = wdt_expired & ~asleep;
  assign ev_wdt_wake = wdt_expired & asleep;
  assign ev_rinstr = reset_instr_in;
  assign ev_over = stack_over_in & stk_rst_en_q;
  assign ev_under = stack_under_in & stk_rst_en_q;
  assign true_rst = ev_brown | ev_ext | ev_wdt_rst | ev_rinstr |
                    ev_over | ev_under;
  assign ev_irq_wake = irq_wake_in & asleep & ~true_rst & ~ev_wdt_wake;
  // Sleep only from run, so flags and state stay in step
  assign ev_sleep = sleep_enter_in & st_q[0] & ~true_rst;

  // ----------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------
  // all clearing conditions
  assign wdt_clear = true_rst | clear_watchdog_instr_in | ev_sleep |
                     ev_wdt_wake | ev_irq_wake | osc_fail_in |
                     ~cfg_valid_q |
                     ~wdt_active(mode_q, sw_enable_q, asleep);

  wdrs_wdt_cnt #(
    .CNT_W(24),
    .BASE_TICKS(BASE_TICKS)
  ) u_cnt (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .tick_in(lf_tick),
    .clear_in(wdt_clear),
    .period_sel_in(period_sel_q),
    .timeout_out(wdt_expired)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apb_acc = psel_in & penable_in;
  assign pready_d = apb_acc & ~pready_out;
  assign wr_en = apb_acc & pready_out & pwrite_in;

  // Read mux and address check
  always @*
  begin
    rdata_d = 32'h0;
    unmapped_d = 1'b0;
    case (paddr_in)
      `WDRS_OFS_STATUS:
      begin
        rdata_d[`WDRS_SR_TIMEOUT_BIT] = timeout_flag_out;
        rdata_d[`WDRS_SR_POWERDOWN_BIT] = powerdown_flag_out;
      end
      `WDRS_OFS_PWRCTL: rdata_d[7:0] = pwr_q;
      `WDRS_OFS_WDCTL:
      begin
        rdata_d[`WDRS_WC_SWEN_BIT] = sw_enable_q;
        rdata_d[`WDRS_WC_PSEL_MSB:`WDRS_WC_PSEL_LSB] = period_sel_q;
      end
      default: unmapped_d = 1'b1;
    endcase
  end

  // Two-cycle access: ready one cycle after penable
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end
    else
    begin
      pready_out <= pready_d;
      pslverr_out <= pready_d & unmapped_d;
      if (pready_d)
        prdata_out <= pwrite_in ? 32'h0 : rdata_d;
    end
  end

  // Watchdog control register
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sw_enable_q <= 1'b0;
      period_sel_q <= `WDRS_WC_PSEL_RST;
    end
    else if (true_rst)
    begin
      sw_enable_q <= 1'b0;
      period_sel_q <= `WDRS_WC_PSEL_RST;
    end
    else if (wr_en && paddr_in == `WDRS_OFS_WDCTL)
    begin
      sw_enable_q <= pwdata_in[`WDRS_WC_SWEN_BIT];
      period_sel_q <= pwdata_in[`WDRS_WC_PSEL_MSB:`WDRS_WC_PSEL_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Status and cause flags
  // ----------------------------------------------------------------
  // flags record the highest-priority event of the cycle; hardware beats software
  always @*
  begin
    pwr_d = pwr_q;
    timeout_d = timeout_flag_out;
    powerdown_d = powerdown_flag_out;
    if (wr_en && paddr_in == `WDRS_OFS_PWRCTL)
      pwr_d = pwdata_in[7:0] & `WDRS_PW_WMASK;
    if (ev_brown)
    begin
      pwr_d[`WDRS_PW_STACK_OVER_BIT] = 1'b0;
      pwr_d[`WDRS_PW_STACK_UNDER_BIT] = 1'b0;
      pwr_d[`WDRS_PW_EXT_RESET_BIT] = 1'b1;
      pwr_d[`WDRS_PW_RESET_INSTR_BIT] = 1'b1;
      pwr_d[`WDRS_PW_BROWN_OUT_BIT] = 1'b0;
      timeout_d = 1'b1;
      powerdown_d = 1'b1;
    end
    else if (ev_ext)
    begin
      pwr_d[`WDRS_PW_EXT_RESET_BIT] = 1'b0;
      if (asleep)
      begin
        timeout_d = 1'b1;
        powerdown_d = 1'b0;
      end
    end
    else if (ev_wdt_rst)
    begin
      pwr_d[`WDRS_PW_WDT_RESET_BIT] = 1'b0;
      timeout_d = 1'b0;
    end
    else if (ev_rinstr)
      pwr_d[`WDRS_PW_RESET_INSTR_BIT] = 1'b0;
    else if (ev_over)
      pwr_d[`WDRS_PW_STACK_OVER_BIT] = 1'b1;
    else if (ev_under)
      pwr_d[`WDRS_PW_STACK_UNDER_BIT] = 1'b1;
    else if (ev_wdt_wake)
    begin
      timeout_d = 1'b0;
      powerdown_d = 1'b0;
    end
    else if (ev_irq_wake)
    begin
      timeout_d = 1'b1;
      powerdown_d = 1'b0;
    end
    else if (ev_sleep)
    begin
      timeout_d = 1'b1;
      powerdown_d = 1'b0;
    end
    else if (clear_watchdog_instr_in)
    begin
      timeout_d = 1'b1;
      powerdown_d = 1'b1;
    end
  end

  // Flag registers, power-on values
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pwr_q <= `WDRS_PW_RST_VAL;
      timeout_flag_out <= 1'b1;
      powerdown_flag_out <= 1'b1;
    end
    else
    begin
      pwr_q <= pwr_d;
      timeout_flag_out <= timeout_d;
      powerdown_flag_out <= powerdown_d;
    end
  end

  // ----------------------------------------------------------------
  // Sleep and program counter sequencing
  // ----------------------------------------------------------------
  assign pc_next16 = {{(16-PC_W){1'b0}}, pc_in} + 16'h0001;
  assign reset_vec = `WDRS_RESET_VEC;
  assign irq_vec = `WDRS_IRQ_VEC;

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q <= ST_RUN;
      core_reset_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_value_out <= {PC_W{1'b0}};
      irq_push_out <= 1'b0;
      asleep_out <= 1'b0;
    end
    else
    begin
      core_reset_out <= 1'b0;
      pc_load_out <= 1'b0;
      irq_push_out <= 1'b0;
      if (true_rst)
      begin
        st_q <= ST_RUN;
        core_reset_out <= 1'b1;
        pc_load_out <= 1'b1;
        pc_value_out <= reset_vec[PC_W-1:0];
        asleep_out <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_RUN:
            if (ev_sleep)
            begin
              st_q <= ST_SLEEP;
              asleep_out <= 1'b1;
            end
          ST_SLEEP:
            if (ev_wdt_wake || ev_irq_wake)
            begin
              pc_load_out <= 1'b1;
              pc_value_out <= pc_next16[PC_W-1:0];
              asleep_out <= 1'b0;
              if (ev_irq_wake && global_irq_enable_in)
                st_q <= ST_VEC;
              else
                st_q <= ST_RUN;
            end
          ST_VEC:
            if (instr_retired_in)
            begin
              irq_push_out <= 1'b1;
              pc_load_out <= 1'b1;
              pc_value_out <= irq_vec[PC_W-1:0];
              st_q <= ST_RUN;
            end
          default:
            st_q <= ST_RUN;
        endcase
      end
    end
  end

endmodule // wdrs_top

// file: testbench/wdrs_checker.sv
`timescale 1ns/10ps
module wdrs_checker #(
  parameter PC_W = 15,
  parameter BASE_TICKS = 31
) (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pready_out,
  input wire pslverr_out,
  input wire ext_reset_pin_n_in,
  input wire irq_wake_in,
  input wire [PC_W-1:0] pc_in,
  input wire core_reset_out,
  input wire pc_load_out,
  input wire [PC_W-1:0] pc_value_out,
  input wire irq_push_out,
  input wire asleep_out,
  input wire timeout_flag_out,
  input wire powerdown_flag_out
);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in;
  endsequence
  sequence s_wake;
    $fell(asleep_out) && pc_load_out && !core_reset_out;
  endsequence
  AST_APB_LATENCY: assert property (s_setup ##1 s_access |=> pready_out)
    else $error("access phase not answered in time");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  AST_SLVERR_READY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_RESET_PC_ZERO: assert property (core_reset_out |-> pc_load_out && pc_value_out == 0)
    else $error("true reset without zero load");
  AST_PUSH_VECTOR: assert property (irq_push_out |-> pc_load_out && pc_value_out == 4)
    else $error("push without vector load");
  AST_WAKE_NEXT_PC: assert property (s_wake |-> pc_value_out == $past(pc_in) + 1'b1)
    else $error("wake address wrong");
  AST_PIN_RESET: assert property ($fell(ext_reset_pin_n_in) |-> ##[1:6] core_reset_out)
    else $error("pin event gave no reset");
  AST_RESET_RUNS: assert property (core_reset_out |-> ##[0:1] !asleep_out)
    else $error("still asleep after reset");
  AST_IRQ_WAKE: assert property (asleep_out && irq_wake_in |=> pc_load_out && timeout_flag_out && !powerdown_flag_out)
    else $error("interrupt wake flags wrong");
endmodule // wdrs_checker

bind wdrs_top wdrs_checker #(.PC_W(PC_W), .BASE_TICKS(BASE_TICKS)) wdrs_checker_i (
  .clk_sys_in, .arst_n_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
  .ext_reset_pin_n_in, .irq_wake_in, .pc_in, .core_reset_out, .pc_load_out,
  .pc_value_out, .irq_push_out, .asleep_out, .timeout_flag_out,
  .powerdown_flag_out);

// file: testbench/tb_watchdog_and_reset_status.sv
`timescale 1ns/10ps
module tb_watchdog_and_reset_status;
  localparam int OSCF = 0, CLR = 1, RSI = 2, SLP = 3, RET = 4, OVF = 5, UNF = 6;
  logic clk_sys_in, arst_n_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, stack_reset_enable_in, low_freq_int_osc_in;
  logic [1:0] watchdog_mode_cfg_in;
  logic ext_reset_pin_n_in, brown_out_reset_in, irq_wake_in;
  logic global_irq_enable_in, core_reset_out, pc_load_out, irq_push_out;
  logic asleep_out, timeout_flag_out, powerdown_flag_out, mon_en;
  logic [6:0] pv;
  logic [14:0] pc_in, pc_value_out, pcn;
  logic [32:0] rq[$];
  logic [16:0] eq[$];
  int errors, samples_checked;

  wdrs_top #(.PC_W(15), .BASE_TICKS(4)) wdrs_top_i (
    .clk_sys_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .watchdog_mode_cfg_in,
    .stack_reset_enable_in, .low_freq_int_osc_in, .ext_reset_pin_n_in,
    .brown_out_reset_in, .osc_fail_in(pv[OSCF]),
    .clear_watchdog_instr_in(pv[CLR]), .reset_instr_in(pv[RSI]),
    .sleep_enter_in(pv[SLP]), .irq_wake_in, .global_irq_enable_in,
    .instr_retired_in(pv[RET]), .stack_over_in(pv[OVF]),
    .stack_under_in(pv[UNF]), .pc_in, .core_reset_out, .pc_load_out,
    .pc_value_out, .irq_push_out, .asleep_out, .timeout_flag_out,
    .powerdown_flag_out);

  // ----------------------------------------
  // Clock, report and compare tasks
  // ----------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bad(input logic [32:0] got, input logic [32:0] exp);
    errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp)
      bad(got, exp);
  endtask

  task automatic cmp_ev(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp)
      bad({16'h0, got}, {16'h0, exp});
  endtask

  // Output watcher takes the oldest note
  always @(posedge clk_sys_in)
  begin
    if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1)
      cmp_rd({pslverr_out, prdata_out}, rq.size() ? rq.pop_front() : '1);
    if (mon_en && pc_load_out === 1'b1)
      cmp_ev({core_reset_out, irq_push_out, pc_value_out}, eq.size() ? eq.pop_front() : '1);
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n == 20)
    begin
      errors++;
      results();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic exp_ev(input logic c, input logic p, input logic [14:0] v);
    eq.push_back({c, p, v});
  endtask

  task automatic settle;
    int n;
    n = 0;
    while (eq.size() != 0 && n < 40)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    if (eq.size() != 0)
    begin
      errors++;
      results();
    end
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys_in);
    pv[k] <= 1'b1;
    @(posedge clk_sys_in);
    pv[k] <= 1'b0;
    settle();
  endtask

  task automatic ticks(input int n);
    bit want;
    want = eq.size() != 0;
    for (int i = 0; i < n && !(want && eq.size() == 0); i++)
    begin
      low_freq_int_osc_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      low_freq_int_osc_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
    end
    settle();
  endtask

  task automatic pin(input int k);
    if (k)
      brown_out_reset_in <= 1'b1;
    else
      ext_reset_pin_n_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    brown_out_reset_in <= 1'b0;
    ext_reset_pin_n_in <= 1'b1;
    settle();
  endtask

  task automatic por(input logic [1:0] m, input logic s);
    mon_en = 1'b0;
    arst_n_in <= 1'b0;
    watchdog_mode_cfg_in <= m;
    stack_reset_enable_in <= s;
    global_irq_enable_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    mon_en = 1'b1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    errors = 0;
    samples_checked = 0;
    mon_en = 1'b0;
    {arst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {low_freq_int_osc_in, brown_out_reset_in, irq_wake_in, pv} = '0;
    {watchdog_mode_cfg_in, stack_reset_enable_in} = 3'h7;
    global_irq_enable_in = 1'b0;
    ext_reset_pin_n_in = 1'b1;
    pc_in = 15'($urandom(32'hb095));
    por(2'h3, 1'b1);
    rd(8'h00, 33'h18);
    rd(8'h04, 33'h1c);
    rd(8'h08, 33'h16);
    rd(8'h0c, 33'h1_0000_0000);
    apb(1'b1, 8'h08, 32'h0);
    repeat (5)
    begin
      ticks(2);
      pulse(CLR);
      ticks(2);
      pulse(OSCF);
    end
    exp_ev(1'b1, 1'b0, 15'h0);
    ticks(20);
    rd(8'h00, 33'h08);
    rd(8'h04, 33'h0c);
    rd(8'h08, 33'h16);
    exp_ev(1'b1, 1'b0, 15'h0);
    pulse(RSI);
    rd(8'h04, 33'h08);
    exp_ev(1'b1, 1'b0, 15'h0);
    pulse(OVF);
    exp_ev(1'b1, 1'b0, 15'h0);
    pulse(UNF);
    rd(8'h04, 33'hc8);
    exp_ev(1'b1, 1'b0, 15'h0);
    pin(0);
    rd(8'h04, 33'hc0);
    rd(8'h00, 33'h08);
    apb(1'b1, 8'h04, 32'hff);
    rd(8'h04, 33'hdf);
    // Watchdog expiry while asleep wakes
    apb(1'b1, 8'h08, 32'h0);
    pulse(SLP);
    rd(8'h00, 33'h10);
    cmp_rd({32'h0, asleep_out}, 33'h1);
    pcn = 15'($urandom);
    pc_in <= pcn;
    exp_ev(1'b0, 1'b0, pcn + 15'h1);
    ticks(20);
    rd(8'h00, 33'h00);
    cmp_rd({32'h0, asleep_out}, 33'h0);
    rd(8'h04, 33'hdf);
    // Interrupt wake then vector push
    pulse(SLP);
    global_irq_enable_in <= 1'b1;
    exp_ev(1'b0, 1'b0, pc_in + 15'h1);
    irq_wake_in <= 1'b1;
    settle();
    irq_wake_in <= 1'b0;
    rd(8'h00, 33'h10);
    exp_ev(1'b0, 1'b1, 15'h4);
    pulse(RET);
    pulse(SLP);
    exp_ev(1'b1, 1'b0, 15'h0);
    pin(0);
    rd(8'h00, 33'h10);
    rd(8'h04, 33'hd7);
    exp_ev(1'b1, 1'b0, 15'h0);
    pin(1);
    rd(8'h04, 33'h1e);
    rd(8'h00, 33'h18);
    // Mode off, stack resets disabled
    por(2'h0, 1'b0);
    apb(1'b1, 8'h08, 32'h1);
    pulse(OVF);
    ticks(20);
    rd(8'h04, 33'h1c);
    // Software controlled mode
    por(2'h1, 1'b1);
    apb(1'b1, 8'h08, 32'h0);
    ticks(20);
    apb(1'b1, 8'h08, 32'h1);
    exp_ev(1'b1, 1'b0, 15'h0);
    ticks(20);
    // Off in sleep, active awake
    por(2'h2, 1'b1);
    apb(1'b1, 8'h08, 32'h0);
    pulse(SLP);
    ticks(20);
    exp_ev(1'b0, 1'b0, pc_in + 15'h1);
    irq_wake_in <= 1'b1;
    settle();
    irq_wake_in <= 1'b0;
    exp_ev(1'b1, 1'b0, 15'h0);
    ticks(20);
    repeat (10) @(posedge clk_sys_in);
    results();
  end
endmodule // tb_watchdog_and_reset_status
